// >>> bench/acm_chk.sv
// Checker for clock source choice and divider
`timescale 1ns/10ps
module acm_chk (
  input wire       core_clk,
  input wire       sys_rst,
  input wire       clk_pin_in,
  input wire [3:0] output_sample_rate,
  input wire       int_osc_enable,
  input wire       ext_clk_selected,
  input wire       source_switch_pulse,
  input wire       modulator_clock_rate,
  input wire       mod_tick,
  input wire [7:0] mod_div_ratio
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // Raw edges seen; never fewer than the synchroniser saw
  // Forgets a burst later than the design does, so it never undercounts
  reg [2:0] ecnt;
  reg       pin_q;
  reg [8:0] quiet;
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ecnt  <= 3'h0;
      pin_q <= 1'b0;
      quiet <= 9'h000;
    end else begin
      pin_q <= clk_pin_in;
      if (pin_q != clk_pin_in) begin
        quiet <= 9'h000;
        if (ecnt != 3'h4) begin
          ecnt <= ecnt + 3'h1;
        end
      end else if (quiet != 9'h0FA) begin
        quiet <= quiet + 9'h001;
      end else if (!ext_clk_selected) begin
        ecnt <= 3'h0;
      end
    end
  end
  osc_excl_a: assert property (int_osc_enable != ext_clk_selected)
    else $error("source flags clash");
  edge_count_a: assert property (ext_clk_selected |-> ecnt == 3'h4)
    else $error("switch too early");
  no_return_a: assert property (!$fell(ext_clk_selected))
    else $error("source reverted");
  switch_pulse_a: assert property (source_switch_pulse |-> $rose(ext_clk_selected) && !int_osc_enable)
    else $error("stray switch pulse");
  switch_seen_a: assert property ($rose(ext_clk_selected) |-> source_switch_pulse)
    else $error("switch without pulse");
  ratio_set_a: assert property (mod_div_ratio inside {8'h80, 8'h20, 8'h10, 8'h08})
    else $error("bad ratio");
  ratio_hold_a: assert property ($changed(mod_div_ratio) |-> mod_tick || source_switch_pulse
    || $past(mod_tick | source_switch_pulse)) else $error("ratio moved mid period");
  min_period_a: assert property (mod_tick |=> !mod_tick [*7])
    else $error("period too short");
  tick_fall_a: assert property (mod_tick |-> $fell(modulator_clock_rate))
    else $error("tick off clock");
  cover property ($rose(ext_clk_selected));
  cover property (source_switch_pulse);
  cover property (mod_tick && mod_div_ratio == 8'h08);
  cover property (mod_tick && mod_div_ratio == 8'h80);
endmodule
bind acm_clock_ctrl acm_chk u_chk (.core_clk, .sys_rst, .clk_pin_in, .output_sample_rate,
  .int_osc_enable, .ext_clk_selected, .source_switch_pulse, .modulator_clock_rate,
  .mod_tick, .mod_div_ratio);

// >>> bench/acm_ext_src.sv
// Far-side clock source on the clock pin
`timescale 1ns/10ps
module acm_ext_src (
  input  wire       run,
  input  wire [7:0] half_ns,
  output reg        pin
);
  initial pin = 1'b0;
  always @(posedge run) begin
    // Phase offset keeps pin edges away from the core clock edge
    #3;
    while (run) begin
      #(half_ns) if (run) pin = ~pin;
    end
    // Back to ground, which is an edge only if the pin was left high
    pin = 1'b0;
  end
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for clock source and divider
`timescale 1ns/10ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("FAIL %s exp %0h got %0h", n, e, a); end end
module tb_top;
  reg        core_clk = 1'b0;
  reg        sys_rst  = 1'b1;
  reg  [3:0] rate     = 4'h0;
  reg        run      = 1'b0;
  wire       pin, osc, ext, mclk, tick;
  wire [7:0] ratio;
  int        fail_count = 0;
  int        n_checks   = 0;
  always #5 core_clk = ~core_clk;
  acm_ext_src u_src (.run(run), .half_ns(8'h32), .pin(pin));
  acm_clock_ctrl u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .clk_pin_in(pin),
    .output_sample_rate(rate), .int_osc_enable(osc), .ext_clk_selected(ext),
    .source_switch_pulse(), .modulator_clock_rate(mclk), .mod_tick(tick),
    .mod_div_ratio(ratio));
  task automatic gap(output int n, output int h);
    n = 0;
    h = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
      if (mclk === 1'b1) h++;
    end while (tick !== 1'b1 && n < 400);
  endtask
  task automatic t_reset;
    @(posedge core_clk) sys_rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (300) @(posedge core_clk);
    #1 `CHK("osc", 1'b1, osc)
    `CHK("ratio", 8'h80, ratio)
  endtask
  task automatic t_rates;
    int n;
    int h;
    reg [7:0] e;
    for (int c = 0; c < 11; c++) begin
      e = c < 3 ? 8'h80 : c < 6 ? 8'h20 : c < 9 ? 8'h10 : c == 9 ? 8'h08 : 8'h80;
      @(posedge core_clk) rate <= (c == 10) ? 4'hF : c[3:0];
      gap(n, h);
      gap(n, h);
      gap(n, h);
      `CHK("ratio", e, ratio)
      `CHK("period", e, n)
      `CHK("mclk high", e >> 1, h)
    end
  endtask
  // Two short bursts split by a long gap must not latch
  task automatic t_short;
    repeat (2) begin
      @(posedge core_clk) run <= 1'b1;
      #120 run <= 1'b0;
      repeat (300) @(posedge core_clk);
    end
    #1 `CHK("ext", 1'b0, ext)
    `CHK("osc", 1'b1, osc)
  endtask
  // Fourth edge lands after cycle 20; two sync flops and the ext_clk_selected flop add three
  task automatic t_switch;
    int n;
    int h;
    @(posedge core_clk) run <= 1'b1;
    n = 0;
    while (ext !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    `CHK("switch time", 23, n)
    `CHK("osc", 1'b0, osc)
    run <= 1'b0;
    repeat (300) @(posedge core_clk);
    #1 `CHK("ext", 1'b1, ext)
    gap(n, h);
    gap(n, h);
    `CHK("period", 8'h80, n)
    `CHK("mclk high", 8'h40, h)
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    t_reset; t_rates; t_short; t_switch; t_reset;
    end_sim;
  end
  // Several times the expected run
  initial begin
    #400000 fail_count++;
    end_sim;
  end
endmodule

// >>> core/acm_clock_ctrl.v
// Clock source choice and modulator clock divider
// Summary of operation
// - Clock pin held low through reset keeps the internal oscillator selected.
// - An external clock seen on the pin disables the oscillator and switches over.
// - External selection stays latched until device reset.
// - Divide ratio 128, 32, 16 or 8 by data-rate group.
// - Nominal clock gives modulator rate from 32 kHz up to 512 kHz.
// - Same divide ratios apply for internal or external source.
// - Modulator rate scales directly with the actual system clock.
`timescale 1ns/10ps
`include "acm_consts.vh"
module acm_clock_ctrl (
  core_clk,
  sys_rst,
  clk_pin_in,
  output_sample_rate,
  int_osc_enable,
  ext_clk_selected,
  source_switch_pulse,
  modulator_clock_rate,
  mod_tick,
  mod_div_ratio
);
  input  wire                     core_clk;
  input  wire                     sys_rst;
  input  wire                     clk_pin_in;
  input  wire [`ACM_RATE_W-1:0]   output_sample_rate;
  output reg                      int_osc_enable;
  output reg                      ext_clk_selected;
  output reg                      source_switch_pulse;
  output reg                      modulator_clock_rate;
  output reg                      mod_tick;
  output reg  [`ACM_DIV_W-1:0]    mod_div_ratio;

  localparam ST_INTERNAL = 2'b00;
  localparam ST_DETECT   = 2'b01;
  localparam ST_EXTERNAL = 2'b10;

  wire                       pin_sync;
  reg                        pin_prev;
  reg  [1:0]                 state;
  reg  [1:0]                 next_state;
  reg  [`ACM_EDGE_CNT_W-1:0] edge_cnt;
  reg  [`ACM_GAP_W-1:0]      gap_cnt;
  reg  [`ACM_DIV_W-1:0]      div_cnt;
  reg  [`ACM_DIV_W-1:0]      next_ratio;
  wire                       pin_edge;
  wire                       gap_expired;
  wire                       enough_edges;
  wire                       going_external;
  wire                       period_end;
  wire                       half_point;

  // Pin is asynchronous to the core clock
  acm_sync2 u_pin_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (clk_pin_in),
    .sync_out (pin_sync)
  );

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_sync;
    end
  end

  assign pin_edge       = pin_sync ^ pin_prev;
  // A lone glitch is forgotten once the pin sits still too long
  assign gap_expired    = (gap_cnt == `ACM_GAP_LAST);
  assign enough_edges   = pin_edge && (edge_cnt == `ACM_EDGE_LAST);
  assign going_external = (next_state == ST_EXTERNAL) && (state != ST_EXTERNAL);

  always @* begin
    next_state = state;
    case (state)
      ST_INTERNAL: begin
        if (pin_edge) begin
          next_state = ST_DETECT;
        end
      end
      ST_DETECT: begin
        if (enough_edges) begin
          next_state = ST_EXTERNAL;
        end else if (!pin_edge && gap_expired) begin
          next_state = ST_INTERNAL;
        end
      end
      ST_EXTERNAL: begin
        next_state = ST_EXTERNAL;
      end
      default: begin
        next_state = ST_INTERNAL;
      end
    endcase
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_INTERNAL;
    end else begin
      state <= next_state;
    end
  end

  // First edge is counted on entry to detection
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      edge_cnt <= {`ACM_EDGE_CNT_W{1'b0}};
    end else if (state != ST_DETECT) begin
      edge_cnt <= {{(`ACM_EDGE_CNT_W-1){1'b0}}, 1'b1};
    end else if (pin_edge) begin
      edge_cnt <= edge_cnt + 1'b1;
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_cnt <= {`ACM_GAP_W{1'b0}};
    end else if (pin_edge || state != ST_DETECT) begin
      gap_cnt <= {`ACM_GAP_W{1'b0}};
    end else begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end

  // Flags are registered so the clock mux outside sees clean levels
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_osc_enable      <= 1'b1;
      ext_clk_selected    <= 1'b0;
      source_switch_pulse <= 1'b0;
    end else begin
      int_osc_enable      <= (next_state != ST_EXTERNAL);
      ext_clk_selected    <= (next_state == ST_EXTERNAL);
      source_switch_pulse <= going_external;
    end
  end

  // Same ratio table whatever the source
  // Unknown codes fall back to the slowest modulator rate
  always @* begin
    case (output_sample_rate)
      `ACM_RATE_5: begin
        next_ratio = `ACM_DIV_128;
      end
      `ACM_RATE_10: begin
        next_ratio = `ACM_DIV_128;
      end
      `ACM_RATE_20: begin
        next_ratio = `ACM_DIV_128;
      end
      `ACM_RATE_40: begin
        next_ratio = `ACM_DIV_32;
      end
      `ACM_RATE_80: begin
        next_ratio = `ACM_DIV_32;
      end
      `ACM_RATE_160: begin
        next_ratio = `ACM_DIV_32;
      end
      `ACM_RATE_320: begin
        next_ratio = `ACM_DIV_16;
      end
      `ACM_RATE_640: begin
        next_ratio = `ACM_DIV_16;
      end
      `ACM_RATE_1000: begin
        next_ratio = `ACM_DIV_16;
      end
      `ACM_RATE_2000: begin
        next_ratio = `ACM_DIV_8;
      end
      default: begin
        next_ratio = `ACM_DIV_128;
      end
    endcase
  end

  assign period_end = (div_cnt == mod_div_ratio - 1'b1);
  assign half_point = (div_cnt == (mod_div_ratio >> 1) - 1'b1);

  // Divider counts system clock cycles only, so rate tracks that clock
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt <= {`ACM_DIV_W{1'b0}};
    end else if (source_switch_pulse) begin
      div_cnt <= {`ACM_DIV_W{1'b0}};
    end else if (period_end) begin
      div_cnt <= {`ACM_DIV_W{1'b0}};
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // Ratio changes take effect at period end to avoid a short pulse
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mod_div_ratio <= `ACM_DIV_128;
    end else if (!source_switch_pulse && period_end) begin
      mod_div_ratio <= next_ratio;
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      modulator_clock_rate <= 1'b0;
    end else if (source_switch_pulse || period_end) begin
      modulator_clock_rate <= 1'b0;
    end else if (half_point) begin
      modulator_clock_rate <= 1'b1;
    end
  end

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mod_tick <= 1'b0;
    end else begin
      mod_tick <= !source_switch_pulse && period_end;
    end
  end
endmodule

// >>> core/acm_consts.vh
// Constants for the converter clock source and modulator divider
`ifndef ACM_CONSTS_VH
`define ACM_CONSTS_VH
`define ACM_CLK_PERIOD_NS   10
`define ACM_SYS_CLK_HZ      4096000
`define ACM_DETECT_EDGES    4
`define ACM_EDGE_CNT_W      3
`define ACM_EDGE_LAST       3'h3
`define ACM_GAP_TIME_NS     2000
`define ACM_GAP_CYCLES      ((`ACM_GAP_TIME_NS + `ACM_CLK_PERIOD_NS - 1) / `ACM_CLK_PERIOD_NS)
`define ACM_GAP_W           8
`define ACM_GAP_LAST        8'hC7
`define ACM_RATE_W          4
`define ACM_RATE_5          4'h0
`define ACM_RATE_10         4'h1
`define ACM_RATE_20         4'h2
`define ACM_RATE_40         4'h3
`define ACM_RATE_80         4'h4
`define ACM_RATE_160        4'h5
`define ACM_RATE_320        4'h6
`define ACM_RATE_640        4'h7
`define ACM_RATE_1000       4'h8
`define ACM_RATE_2000       4'h9
`define ACM_DIV_W           8
`define ACM_DIV_128         8'h80
`define ACM_DIV_32          8'h20
`define ACM_DIV_16          8'h10
`define ACM_DIV_8           8'h08
`endif

// >>> core/acm_sync2.v
// Two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
module acm_sync2 (
  core_clk,
  sys_rst,
  async_in,
  sync_out
);
  input  wire core_clk;
  input  wire sys_rst;
  input  wire async_in;
  output wire sync_out;

  reg stage1;
  reg stage2;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
    end
  end

  assign sync_out = stage2;
endmodule
